// file: logic/adcc_pkg.sv
package adcc_pkg;
  // ****************************************************************
  // Register map and fields.
  // ****************************************************************
  localparam logic [7:0] OFS_CHANNEL_REF = 8'h00;
  localparam logic [7:0] OFS_CTRL_STATUS = 8'h04;
  localparam logic [7:0] OFS_TRIG_SOURCE = 8'h08;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h0c;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h10;
  localparam logic [7:0] CHANNEL_REF_RESET = 8'h00;
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [2:0] TRIG_SOURCE_RESET = 3'h0;
  localparam int REF_MSB = 7;
  localparam int REF_LSB = 6;
  localparam int LEFT_ADJUST_BIT = 5;
  localparam int CHAN_MSB = 4;
  localparam int ENABLE_BIT = 7;
  localparam int START_BIT = 6;
  localparam int AUTO_BIT = 5;
  localparam int FLAG_BIT = 4;
  localparam int IRQ_EN_BIT = 3;
  localparam int DIV_MSB = 2;
  localparam int TRIG_MSB = 7;
  localparam int TRIG_LSB = 5;
  // ****************************************************************
  // Encodings and timing.
  // ****************************************************************
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
  localparam logic [1:0] REF_INTERNAL = 2'h3;
  localparam logic [4:0] FIRST_CONV_CYCLES = 5'h19;
  localparam logic [4:0] NORMAL_CONV_CYCLES = 5'h0d;
  typedef enum logic [1:0] {gain_x1, gain_x10, gain_x200} adcc_gain_t;
  typedef enum logic [1:0] {src_pins, src_bandgap, src_ground} adcc_src_t;
  typedef enum logic {st_idle, st_convert} adcc_state_t;
endpackage : adcc_pkg

// file: logic/adcc_seq_if.sv
`timescale 1ns/1ps
interface adcc_seq_if;
  logic run;
  logic first;
  logic [2:0] div_code;
  logic done;
  modport ctrl (output run, output first, output div_code, input done);
  modport timer (input run, input first, input div_code, output done);
endinterface : adcc_seq_if

// file: logic/adcc_conv_timer.sv
`timescale 1ns/1ps
module adcc_conv_timer (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Sequencing link.
  adcc_seq_if.timer seq
);
  // ****************************************************************
  // Prescaler and converter clock cycle count.
  // ****************************************************************
  logic [7:0] pre_reg;
  logic [4:0] cyc_reg;
  logic done_reg;
  logic [2:0] shift;
  logic [7:0] div_last;
  logic [4:0] total;
  logic tick;

  always_comb begin
    shift = (seq.div_code == 3'h0) ? 3'h1 : seq.div_code;
    div_last = (8'h01 << shift) - 8'h01;
    total = seq.first ? adcc_pkg::FIRST_CONV_CYCLES : adcc_pkg::NORMAL_CONV_CYCLES;
    tick = (pre_reg == div_last);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg <= 8'h00;
      cyc_reg <= 5'h00;
      done_reg <= 1'b0;
    end else if (!seq.run || done_reg) begin
      pre_reg <= 8'h00;
      cyc_reg <= 5'h00;
      done_reg <= 1'b0;
    end else if (tick) begin
      pre_reg <= 8'h00;
      cyc_reg <= cyc_reg + 5'h01;
      done_reg <= (cyc_reg == total - 5'h01);
    end else begin
      pre_reg <= pre_reg + 8'h01;
    end
  end

  assign seq.done = done_reg;
endmodule : adcc_conv_timer

// file: logic/adcc_ctrl.sv
`timescale 1ns/1ps
module adcc_ctrl (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System events.
  input wire logic [6:0] event_flags,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  output logic conv_irq,
  // Converter core.
  input wire logic [9:0] core_sample,
  output logic core_power,
  output logic core_start,
  output logic [1:0] core_reference,
  output logic internal_ref_on,
  output logic [2:0] core_pos_sel,
  output logic [2:0] core_neg_sel,
  output logic core_diff,
  output adcc_pkg::adcc_gain_t core_gain,
  output adcc_pkg::adcc_src_t core_source,
  output logic result_sign_bit
);
  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [7:0] chan_ref_reg;
  logic enable_reg, auto_reg, flag_reg, irq_en_reg, lock_reg, first_pending_reg, first_reg;
  logic [2:0] div_reg, trig_reg, pos_reg, neg_reg, dec_pos, dec_neg;
  logic [9:0] result_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg, irq_reg, core_start_reg, trig_prev_reg;
  logic [1:0] ref_reg;
  logic diff_reg, sign_reg, dec_diff, int_ref_reg;
  adcc_pkg::adcc_gain_t gain_reg, dec_gain;
  adcc_pkg::adcc_src_t src_reg, dec_src;
  adcc_pkg::adcc_state_t state_reg, state_next;
  logic enable_next, setup, wr_acc, rd_acc, ctrl_wr, mapped;
  logic trig_sel, trig_edge, sw_start, free_restart, start_now;
  logic [7:0] low_byte, high_byte, rd_mux;

  adcc_seq_if seq ();

  adcc_conv_timer u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .seq(seq.timer)
  );

  // ****************************************************************
  // Bus decode and start sources.
  // ****************************************************************
  always_comb begin
    setup = psel && !penable;
    wr_acc = psel && penable && pwrite;
    rd_acc = psel && penable && !pwrite;
    ctrl_wr = wr_acc && (paddr == adcc_pkg::OFS_CTRL_STATUS);
    mapped = (paddr == adcc_pkg::OFS_CHANNEL_REF) || (paddr == adcc_pkg::OFS_CTRL_STATUS) ||
             (paddr == adcc_pkg::OFS_TRIG_SOURCE) || (paddr == adcc_pkg::OFS_RESULT_LOW) ||
             (paddr == adcc_pkg::OFS_RESULT_HIGH);
    enable_next = ctrl_wr ? pwdata[adcc_pkg::ENABLE_BIT] : enable_reg;
    trig_sel = (trig_reg == adcc_pkg::TRIG_FREE_RUN) ? 1'b0 : event_flags[trig_reg - 3'h1];
    trig_edge = auto_reg && trig_sel && !trig_prev_reg;
    sw_start = ctrl_wr && pwdata[adcc_pkg::START_BIT];
    free_restart = seq.done && auto_reg && (trig_reg == adcc_pkg::TRIG_FREE_RUN);
    start_now = enable_next && (((state_reg == adcc_pkg::st_idle) && (sw_start || trig_edge)) ||
                                free_restart);
  end

  // ****************************************************************
  // Channel and gain decode.
  // ****************************************************************
  always_comb begin
    dec_pos = chan_ref_reg[2:0];
    dec_neg = 3'h0;
    dec_diff = 1'b0;
    dec_gain = adcc_pkg::gain_x1;
    dec_src = adcc_pkg::src_pins;
    unique case (chan_ref_reg[4:3])
      2'b00: dec_diff = 1'b0;
      2'b01: begin
        dec_diff = 1'b1;
        dec_pos = {1'b0, chan_ref_reg[2], chan_ref_reg[0]};
        dec_neg = {1'b0, chan_ref_reg[2], 1'b0};
        dec_gain = chan_ref_reg[1] ? adcc_pkg::gain_x200 : adcc_pkg::gain_x10;
      end
      2'b10: begin
        dec_diff = 1'b1;
        dec_neg = 3'h1;
      end
      2'b11: begin
        if (chan_ref_reg[2:1] != 2'b11) begin
          dec_diff = 1'b1;
          dec_neg = 3'h2;
        end else begin
          dec_src = chan_ref_reg[0] ? adcc_pkg::src_ground : adcc_pkg::src_bandgap;
        end
      end
    endcase
  end

  // ****************************************************************
  // Result byte layout.
  // ****************************************************************
  always_comb begin
    if (chan_ref_reg[adcc_pkg::LEFT_ADJUST_BIT]) begin
      high_byte = result_reg[9:2];
      low_byte = {result_reg[1:0], 6'h00};
    end else begin
      high_byte = {6'h00, result_reg[9:8]};
      low_byte = result_reg[7:0];
    end
    rd_mux = 8'h00;
    if (paddr == adcc_pkg::OFS_CHANNEL_REF) begin
      rd_mux = chan_ref_reg;
    end else if (paddr == adcc_pkg::OFS_CTRL_STATUS) begin
      rd_mux = {enable_reg, state_reg == adcc_pkg::st_convert, auto_reg, flag_reg,
                irq_en_reg, div_reg};
    end else if (paddr == adcc_pkg::OFS_TRIG_SOURCE) begin
      rd_mux = {trig_reg, 5'h00};
    end else if (paddr == adcc_pkg::OFS_RESULT_LOW) begin
      rd_mux = low_byte;
    end else if (paddr == adcc_pkg::OFS_RESULT_HIGH) begin
      rd_mux = high_byte;
    end
  end

  // ****************************************************************
  // APB answer.
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      if (setup) begin
        prdata_reg <= {24'h00_0000, rd_mux};
        pslverr_reg <= !mapped;
      end
    end
  end

  // ****************************************************************
  // Software registers.
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chan_ref_reg <= adcc_pkg::CHANNEL_REF_RESET;
      enable_reg <= adcc_pkg::CTRL_STATUS_RESET[adcc_pkg::ENABLE_BIT];
      auto_reg <= adcc_pkg::CTRL_STATUS_RESET[adcc_pkg::AUTO_BIT];
      irq_en_reg <= adcc_pkg::CTRL_STATUS_RESET[adcc_pkg::IRQ_EN_BIT];
      div_reg <= adcc_pkg::CTRL_STATUS_RESET[adcc_pkg::DIV_MSB:0];
      trig_reg <= adcc_pkg::TRIG_SOURCE_RESET;
    end else if (wr_acc) begin
      if (paddr == adcc_pkg::OFS_CHANNEL_REF) begin
        chan_ref_reg <= pwdata[7:0];
      end
      if (paddr == adcc_pkg::OFS_TRIG_SOURCE) begin
        trig_reg <= pwdata[adcc_pkg::TRIG_MSB:adcc_pkg::TRIG_LSB];
      end
      if (ctrl_wr) begin
        enable_reg <= pwdata[adcc_pkg::ENABLE_BIT];
        auto_reg <= pwdata[adcc_pkg::AUTO_BIT];
        irq_en_reg <= pwdata[adcc_pkg::IRQ_EN_BIT];
        div_reg <= pwdata[adcc_pkg::DIV_MSB:0];
      end
    end
  end

  // ****************************************************************
  // Conversion sequencing.
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      adcc_pkg::st_idle: begin
        if (start_now) begin
          state_next = adcc_pkg::st_convert;
        end
      end
      adcc_pkg::st_convert: begin
        if (seq.done && !start_now) begin
          state_next = adcc_pkg::st_idle;
        end
      end
    endcase
    if (!enable_next) begin
      state_next = adcc_pkg::st_idle;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= adcc_pkg::st_idle;
      first_pending_reg <= 1'b0;
      first_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
      core_start_reg <= 1'b0;
      int_ref_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      trig_prev_reg <= trig_sel;
      core_start_reg <= start_now;
      int_ref_reg <= enable_next && (adcc_pkg::REF_INTERNAL ==
        (start_now ? chan_ref_reg[adcc_pkg::REF_MSB:adcc_pkg::REF_LSB] : ref_reg));
      if (start_now) begin
        first_pending_reg <= 1'b0;
        first_reg <= first_pending_reg || !enable_reg;
      end else if (!enable_reg && enable_next) begin
        first_pending_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_reg <= 2'h0;
      pos_reg <= 3'h0;
      neg_reg <= 3'h0;
      diff_reg <= 1'b0;
      gain_reg <= adcc_pkg::gain_x1;
      src_reg <= adcc_pkg::src_pins;
    end else if (start_now) begin
      ref_reg <= chan_ref_reg[adcc_pkg::REF_MSB:adcc_pkg::REF_LSB];
      pos_reg <= dec_pos;
      neg_reg <= dec_neg;
      diff_reg <= dec_diff;
      gain_reg <= dec_gain;
      src_reg <= dec_src;
    end
  end

  // ****************************************************************
  // Result, lock, flag and interrupt.
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= 10'h000;
      sign_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      if (seq.done && (state_reg == adcc_pkg::st_convert) && !lock_reg) begin
        result_reg <= core_sample;
        sign_reg <= diff_reg && core_sample[9];
      end
      if (rd_acc && (paddr == adcc_pkg::OFS_RESULT_LOW)) begin
        lock_reg <= 1'b1;
      end else if (rd_acc && (paddr == adcc_pkg::OFS_RESULT_HIGH)) begin
        lock_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      if (seq.done && (state_reg == adcc_pkg::st_convert) && enable_next) begin
        flag_reg <= 1'b1;
      end else if (irq_vector_ack || (ctrl_wr && pwdata[adcc_pkg::FLAG_BIT])) begin
        flag_reg <= 1'b0;
      end
      irq_reg <= flag_reg && irq_en_reg && global_irq_enable;
    end
  end

  assign seq.run = (state_reg == adcc_pkg::st_convert);
  assign seq.first = first_reg;
  assign seq.div_code = div_reg;

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign conv_irq = irq_reg;
  assign core_power = enable_reg;
  assign core_start = core_start_reg;
  assign core_reference = ref_reg;
  assign internal_ref_on = int_ref_reg;
  assign core_pos_sel = pos_reg;
  assign core_neg_sel = neg_reg;
  assign core_diff = diff_reg;
  assign core_gain = gain_reg;
  assign core_source = src_reg;
  assign result_sign_bit = sign_reg;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  logic [15:0] conv_cnt;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_cnt <= 16'h0000;
    end else if (start_now) begin
      conv_cnt <= 16'h0000;
    end else begin
      conv_cnt <= conv_cnt + 16'h0001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_conv_length: assert property ((seq.done && state_reg == adcc_pkg::st_convert) |->
    conv_cnt == 16'((first_reg ? 16'd25 : 16'd13) << ((div_reg == 3'h0) ? 3'h1 : div_reg)))
    else $error("conversion length wrong");
  a_flag_set: assert property ((seq.done && state_reg == adcc_pkg::st_convert && enable_next)
    |=> flag_reg) else $error("flag not set at completion");
  a_flag_clear: assert property ((irq_vector_ack && !seq.done) |=> !flag_reg)
    else $error("flag not cleared by vector");
  a_irq_gating: assert property (##1 conv_irq ==
    $past(flag_reg && irq_en_reg && global_irq_enable)) else $error("interrupt gating wrong");
  a_disable_abort: assert property ($fell(enable_reg) |-> state_reg == adcc_pkg::st_idle
    && !seq.run) else $error("disable did not abort");
  a_setting_held: assert property ((seq.run && $past(seq.run) && !$past(start_now)) |->
    $stable(core_reference) && $stable(core_pos_sel)) else $error("setting changed mid run");
  a_result_locked: assert property (lock_reg |=> $stable(result_reg))
    else $error("result changed while locked");
  a_high_layout: assert property ((rd_acc && paddr == adcc_pkg::OFS_RESULT_HIGH) |->
    prdata[7:0] == $past(chan_ref_reg[adcc_pkg::LEFT_ADJUST_BIT] ? result_reg[9:2] :
    {6'h00, result_reg[9:8]})) else $error("high byte layout wrong");
  a_start_zero: assert property ((ctrl_wr && !pwdata[6] && !auto_reg && !seq.run)
    |=> !seq.run) else $error("zero start began conversion");
  a_start_reads: assert property ((rd_acc && paddr == adcc_pkg::OFS_CTRL_STATUS) |->
    prdata[6] == $past(seq.run)) else $error("start bit readback wrong");

  c_first_done: cover property (seq.done && first_reg);
  c_free_restart: cover property (free_restart && start_now);
  c_auto_trigger: cover property (trig_edge && start_now);
  c_lock_blocks: cover property (seq.done && lock_reg);
endmodule : adcc_ctrl

// file: dv/adcc_core_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Converter core model.
// ****************************************************************
module adcc_core_model (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control from the block.
  input wire logic core_power,
  input wire logic core_start,
  input wire logic [9:0] level,
  // Sample to the block.
  output logic [9:0] core_sample
);
  // A powered-down core drives a changing pattern, never a stale code.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_sample <= 10'h000;
    end else if (!core_power) begin
      core_sample <= ~core_sample;
    end else if (core_start) begin
      core_sample <= level;
    end
  end
endmodule : adcc_core_model

// file: dv/test_adc_conversion_control.sv
`timescale 1ns/1ps
module test_adc_conversion_control;
  // ****************************************************************
  // Signals.
  // ****************************************************************
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] event_flags = 7'h00;
  logic global_irq_enable = 1'b0;
  logic irq_vector_ack = 1'b0;
  logic conv_irq;
  logic [9:0] core_sample;
  logic core_power;
  logic core_start;
  logic [1:0] core_reference;
  logic internal_ref_on;
  logic [2:0] core_pos_sel;
  logic [2:0] core_neg_sel;
  logic core_diff;
  adcc_pkg::adcc_gain_t core_gain;
  adcc_pkg::adcc_src_t core_source;
  logic result_sign_bit;
  logic [9:0] lvl = 10'h000;
  logic [31:0] rdat;
  logic serr;
  logic [10:0] ec;
  logic [31:0] rnd;
  logic [15:0] eb;
  int seed = 32'hbeea2271;
  int cyc = 0;
  int t_wr;
  int tconv;
  int mismatches = 0;
  int compares = 0;

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  adcc_ctrl DUT (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .event_flags(event_flags),
    .global_irq_enable(global_irq_enable),
    .irq_vector_ack(irq_vector_ack),
    .conv_irq(conv_irq),
    .core_sample(core_sample),
    .core_power(core_power),
    .core_start(core_start),
    .core_reference(core_reference),
    .internal_ref_on(internal_ref_on),
    .core_pos_sel(core_pos_sel),
    .core_neg_sel(core_neg_sel),
    .core_diff(core_diff),
    .core_gain(core_gain),
    .core_source(core_source),
    .result_sign_bit(result_sign_bit)
  );

  adcc_core_model u_core (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .core_power(core_power),
    .core_start(core_start),
    .level(lvl),
    .core_sample(core_sample)
  );

  // ****************************************************************
  // Expectations.
  // ****************************************************************
  // Packs source, gain, differential, positive and negative selects.
  function automatic logic [10:0] exp_sel(input logic [4:0] c);
    logic [1:0] s;
    logic [1:0] g;
    logic d;
    logic [2:0] p;
    logic [2:0] n;
    s = 2'd0;
    g = 2'd0;
    d = 1'b0;
    p = c[2:0];
    n = 3'd0;
    if (c == 5'd30) begin
      s = 2'd1;
    end else if (c == 5'd31) begin
      s = 2'd2;
    end else if (c >= 5'd24) begin
      d = 1'b1;
      n = 3'd2;
    end else if (c >= 5'd16) begin
      d = 1'b1;
      n = 3'd1;
    end else if (c >= 5'd8) begin
      d = 1'b1;
      g = c[1] ? 2'd2 : 2'd1;
      p = (c[2] ? 3'd2 : 3'd0) + {2'b00, c[0]};
      n = c[2] ? 3'd2 : 3'd0;
    end
    return {s, g, d, p, n};
  endfunction : exp_sel

  // High byte above low byte, as software reads them.
  function automatic logic [15:0] exp_bytes(input logic [9:0] v, input logic la);
    return la ? {v, 6'h00} : {6'h00, v};
  endfunction : exp_bytes

  function automatic int div_of(input logic [2:0] code);
    return (code < 3'd2) ? 2 : (1 << code);
  endfunction : div_of

  // ****************************************************************
  // Tasks.
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic ack_irq;
    irq_vector_ack <= 1'b1;
    @(posedge sys_clk);
    irq_vector_ack <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("irq after vector", 32'h0, {31'h0, conv_irq});
  endtask : ack_irq

  // One conversion with a busy read, a mid-run channel write and the result reads.
  task automatic convert(input logic [7:0] cr, input logic [2:0] dv, input int n,
                         input logic [9:0] v);
    ec = exp_sel(cr[4:0]);
    lvl <= v;
    apb(1'b1, adcc_pkg::OFS_CHANNEL_REF, cr);
    apb(1'b1, adcc_pkg::OFS_CTRL_STATUS, 8'hd8 | {5'h00, dv});
    t_wr = cyc;
    apb(1'b0, adcc_pkg::OFS_CTRL_STATUS, 8'h00);
    check("start busy", 32'h1, {31'h0, rdat[6]});
    apb(1'b1, adcc_pkg::OFS_CHANNEL_REF, cr ^ 8'h1f);
    while (conv_irq !== 1'b1) @(posedge sys_clk);
    tconv = cyc - t_wr;
    check("conversion time", n * div_of(dv) + 2, tconv);
    check("core select", {27'h0, ec[10:6]}, {27'h0, core_source, core_gain, core_diff});
    if (ec[10:9] == 2'd0) begin
      check("core pins", {26'h0, ec[5:0]}, {26'h0, core_pos_sel, core_neg_sel});
    end
    check("reference", {30'h0, cr[7:6]}, {30'h0, core_reference});
    check("internal ref", {31'h0, cr[7:6] == 2'b11}, {31'h0, internal_ref_on});
    check("sign", {31'h0, ec[6] && v[9]}, {31'h0, result_sign_bit});
    apb(1'b0, adcc_pkg::OFS_CTRL_STATUS, 8'h00);
    check("status done", {24'h0, 8'h98 | {5'h00, dv}}, rdat);
    apb(1'b0, adcc_pkg::OFS_RESULT_LOW, 8'h00);
    eb = exp_bytes(v, cr[5]);
    check("low byte", {24'h0, eb[7:0]}, rdat);
    apb(1'b1, adcc_pkg::OFS_CHANNEL_REF, cr ^ 8'h3f);
    eb = exp_bytes(v, !cr[5]);
    apb(1'b0, adcc_pkg::OFS_RESULT_HIGH, 8'h00);
    check("high byte", {24'h0, eb[15:8]}, rdat);
  endtask : convert

  task automatic finish_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    global_irq_enable <= 1'b1;
    repeat (2) @(posedge sys_clk);
    apb(1'b0, adcc_pkg::OFS_CTRL_STATUS, 8'h00);
    check("status reset", 32'h0, rdat);
    apb(1'b0, 8'h14, 8'h00);
    check("unmapped error", 32'h1, {31'h0, serr});
    convert(8'hed, 3'h1, 25, 10'h270);
    for (int i = 0; i < 12; i++) begin
      rnd = $random(seed);
      convert(rnd[7:0], {1'b0, rnd[9:8]}, 13, rnd[19:10]);
    end
    apb(1'b1, adcc_pkg::OFS_CTRL_STATUS, 8'h00);
    apb(1'b1, adcc_pkg::OFS_CTRL_STATUS, 8'h80);
    convert(8'h1e, 3'h7, 25, 10'h3ff);
    convert(8'h5f, 3'h2, 13, 10'h000);
    apb(1'b1, adcc_pkg::OFS_TRIG_SOURCE, 8'h20);
    apb(1'b1, adcc_pkg::OFS_CTRL_STATUS, 8'hb8);
    event_flags <= 7'h01;
    @(posedge sys_clk);
    @(posedge sys_clk);
    t_wr = cyc;
    while (conv_irq !== 1'b1) @(posedge sys_clk);
    tconv = cyc - t_wr;
    check("trigger time", 13 * 2 + 2, tconv);
    event_flags <= 7'h00;
    ack_irq();
    apb(1'b1, adcc_pkg::OFS_TRIG_SOURCE, 8'h00);
    apb(1'b1, adcc_pkg::OFS_CTRL_STATUS, 8'hf8);
    while (conv_irq !== 1'b1) @(posedge sys_clk);
    ack_irq();
    while (conv_irq !== 1'b1) @(posedge sys_clk);
    apb(1'b0, adcc_pkg::OFS_CTRL_STATUS, 8'h00);
    check("free run restart", 32'h1, {31'h0, rdat[6]});
    apb(1'b1, adcc_pkg::OFS_CTRL_STATUS, 8'h00);
    apb(1'b0, adcc_pkg::OFS_CTRL_STATUS, 8'h00);
    check("status after abort", 32'h10, rdat);
    check("core power", 32'h0, {31'h0, core_power});
    finish_test();
  end

  // Watchdog: far beyond the longest expected run.
  initial begin
    repeat (30000) @(posedge sys_clk);
    mismatches++;
    $display("unexpected timeout: expected end before cycle %0d seen %0d", 30000, cyc);
    finish_test();
  end
endmodule : test_adc_conversion_control
